// File: sbd_pkg.sv
// package for the subtract datapath: opcodes, address limits, phases, structs
// assumes a four-phase core cycle driven by one clock and a decoder upstream
package sbd_pkg;
  // ==========================================================
  // opcode fields
  localparam logic [5:0] SBD_OP_FILE_HI    = 6'h17; // 0101 11
  localparam logic [5:0] SBD_OP_BORROW_HI  = 6'h16; // 0101 10
  localparam logic [7:0] SBD_OP_LIT_HI     = 8'h08; // 0000 1000
  localparam logic [7:0] SBD_INDEX_LIMIT   = 8'h5F; // 95
  localparam logic [7:0] SBD_ACCESS_SPLIT  = 8'h60; // access bank low/high split
  localparam logic [3:0] SBD_SFR_BANK      = 4'hF;
  localparam logic [7:0] SBD_WREG_RESET    = 8'h00;
  localparam logic [4:0] SBD_FLAGS_RESET   = 5'h00;
  // ==========================================================
  // four phase cycle
  typedef enum logic [1:0] {
    SBD_Q1 = 2'b00,
    SBD_Q2 = 2'b01,
    SBD_Q3 = 2'b10,
    SBD_Q4 = 2'b11
  } sbd_phase_e;
  typedef enum logic [1:0] {
    SBD_OP_NONE = 2'b00,
    SBD_OP_FILE = 2'b01,
    SBD_OP_BORROW = 2'b10,
    SBD_OP_LIT  = 2'b11
  } sbd_op_e;
  // status bits: negative, overflow, zero, digit carry, carry (carry means no borrow)
  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } sbd_flags_s;
  typedef struct packed {
    logic [7:0] value;
    sbd_flags_s flags;
  } sbd_result_s;
endpackage : sbd_pkg

// File: sbd_subtractor.sv
// combinational 8-bit subtractor with status flag generation
// assumes operands are stable during the processing phase
`timescale 1ns/1ns
module sbd_subtractor (
  input  wire logic [7:0]          minuend,
  input  wire logic [7:0]          subtrahend,
  input  wire logic                carry_in,
  output sbd_pkg::sbd_result_s     result
);
  logic [8:0] full;
  logic [4:0] low;
  // ==========================================================
  // a - b - !c done as a + ~b + c, so carry out is not-borrow
  always_comb
  begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    result.value    = full[7:0];
    result.flags.c  = full[8];
    result.flags.digit_carry_flag = low[4];
    result.flags.z  = (full[7:0] == 8'h00);
    result.flags.n  = full[7];
    result.flags.overflow_flag = (minuend[7] != subtrahend[7]) && (full[7] != minuend[7]);
  end
endmodule : sbd_subtractor

// File: sbd_datapath.sv
// subtract datapath: decodes three subtract forms, addresses operand, writes result
// assumes the register file answers a read within the same phase (combinational)
`timescale 1ns/1ns
module sbd_datapath (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [15:0]         instr,
  input  wire logic                instr_valid,
  input  wire logic                ext_set_enable,
  input  wire logic [3:0]          bank_select_register,
  input  wire logic [11:0]         index_base,
  input  wire logic [7:0]          file_rdata,
  output logic [11:0]              file_addr,
  output logic                     file_we,
  output logic [7:0]               file_wdata,
  output logic [7:0]               wreg,
  output sbd_pkg::sbd_flags_s      flags,
  output sbd_pkg::sbd_phase_e      phase,
  output logic                     busy
);
  sbd_pkg::sbd_phase_e next_phase;
  sbd_pkg::sbd_op_e    op;
  sbd_pkg::sbd_op_e    next_op;
  logic                dest;
  logic                next_dest;
  logic [11:0]         next_file_addr;
  logic [7:0]          operand;
  logic [7:0]          next_operand;
  logic [7:0]          literal;
  logic [7:0]          next_literal;
  logic [7:0]          next_wreg;
  sbd_pkg::sbd_flags_s next_flags;
  logic                next_file_we;
  logic [7:0]          next_file_wdata;
  sbd_pkg::sbd_result_s res;
  logic [7:0]          minuend;

  sbd_pkg::sbd_op_e    decoded_op;
  logic                write_file;

  // ==========================================================
  // address resolution
  // access bank, banked, or indexed offset; the indexed form covers only the
  // low part of the access bank, so the special registers above it stay reachable
  function automatic logic [11:0] sbd_resolve(
    input logic [7:0]  f,
    input logic        a,
    input logic        ext,
    input logic [3:0]  bank,
    input logic [11:0] base
  );
    logic [11:0] r;
    r = 12'h000;
    if (a)
      r = {bank, f};
    else if (ext && (f <= sbd_pkg::SBD_INDEX_LIMIT))
      r = base + {4'h0, f};                                      // wraps in 4K
    else if (f < sbd_pkg::SBD_ACCESS_SPLIT)
      r = {4'h0, f};
    else
      r = {sbd_pkg::SBD_SFR_BANK, f};
    return r;
  endfunction : sbd_resolve

  // ==========================================================
  // opcode decode
  // words outside the three subtract forms decode as none, so a foreign
  // word runs its four phases without touching wreg, flags or the file
  function automatic sbd_pkg::sbd_op_e sbd_decode(
    input logic [15:0] word,
    input logic        valid
  );
    sbd_pkg::sbd_op_e k;
    k = sbd_pkg::SBD_OP_NONE;
    if (!valid)
      k = sbd_pkg::SBD_OP_NONE;
    else if (word[15:10] == sbd_pkg::SBD_OP_FILE_HI)
      k = sbd_pkg::SBD_OP_FILE;
    else if (word[15:10] == sbd_pkg::SBD_OP_BORROW_HI)
      k = sbd_pkg::SBD_OP_BORROW;
    else if (word[15:8] == sbd_pkg::SBD_OP_LIT_HI)
      k = sbd_pkg::SBD_OP_LIT;
    return k;
  endfunction : sbd_decode

  // ==========================================================
  // operand steering
  // the literal form always lands in wreg, whatever bit 9 of its word holds
  assign decoded_op = sbd_decode(instr, instr_valid);
  assign minuend    = (op == sbd_pkg::SBD_OP_LIT) ? literal : operand;
  assign busy       = (op != sbd_pkg::SBD_OP_NONE);
  assign write_file = (op != sbd_pkg::SBD_OP_LIT) && dest;

  // the borrow form feeds the stored carry back in; the others subtract plainly
  sbd_subtractor u_sub (
    .minuend    (minuend),
    .subtrahend (wreg),
    .carry_in   ((op == sbd_pkg::SBD_OP_BORROW) ? flags.c : 1'b1),
    .result     (res)
  );

  // ==========================================================
  // phase sequencer
  // free-running four-phase count; it never stalls, so the decoder must
  // present each word in Q1 and may send one every four clocks
  always_comb
  begin
    next_phase = sbd_pkg::sbd_phase_e'(phase + 2'b01);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase <= sbd_pkg::SBD_Q1;
    end
    else
    begin
      phase <= next_phase;
    end
  end

  // ==========================================================
  // decode and operand fetch
  always_comb
  begin
    next_op        = op;
    next_dest      = dest;
    next_literal   = literal;
    next_file_addr = file_addr;
    next_operand   = operand;
    case (phase)
      sbd_pkg::SBD_Q1:
      begin
        // the address is resolved for foreign words too; it is never used then
        next_op        = decoded_op;
        next_dest      = instr[9];
        next_literal   = instr[7:0];
        next_file_addr = sbd_resolve(instr[7:0], instr[8], ext_set_enable,
                                     bank_select_register, index_base);
      end
      sbd_pkg::SBD_Q2:
      begin
        next_operand = file_rdata;                                 // operand read
      end
      sbd_pkg::SBD_Q3:
      begin
        next_operand = operand;                                    // held for the subtractor
      end
      sbd_pkg::SBD_Q4:
      begin
        next_op = sbd_pkg::SBD_OP_NONE;                            // write ends the cycle
      end
      default:
      begin
        next_op = sbd_pkg::SBD_OP_NONE;
      end
    endcase
  end

  // registers of the decode group; reset leaves the datapath idle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      op        <= sbd_pkg::SBD_OP_NONE;
      dest      <= 1'b0;
      literal   <= 8'h00;
      file_addr <= 12'h000;
      operand   <= 8'h00;
    end
    else
    begin
      op        <= next_op;
      dest      <= next_dest;
      literal   <= next_literal;
      file_addr <= next_file_addr;
      operand   <= next_operand;
    end
  end

  // ==========================================================
  // result and write back
  // flags, and wreg when it is the destination, move once per subtract, at the end of Q3; the file write
  // strobe then stands through Q4 so the write lands on the next Q1 edge
  always_comb
  begin
    next_wreg       = wreg;
    next_flags      = flags;
    next_file_we    = 1'b0;
    next_file_wdata = file_wdata;
    case (phase)
      sbd_pkg::SBD_Q3:
      begin
        if (op != sbd_pkg::SBD_OP_NONE)
        begin
          next_flags = res.flags;
          if (write_file)
          begin
            next_file_we    = 1'b1;
            next_file_wdata = res.value;
          end
          else
          begin
            next_wreg = res.value;
          end
        end
      end
      default:
      begin
        next_file_we = 1'b0;
      end
    endcase
  end

  // registers of the result group; file_we is high during Q4 only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wreg       <= sbd_pkg::SBD_WREG_RESET;
      flags      <= sbd_pkg::sbd_flags_s'(sbd_pkg::SBD_FLAGS_RESET);
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
    end
    else
    begin
      wreg       <= next_wreg;
      flags      <= next_flags;
      file_we    <= next_file_we;
      file_wdata <= next_file_wdata;
    end
  end
endmodule : sbd_datapath

// File: sbd_rf_model.sv
// register file model facing the subtract datapath
// assumes address and write data stand with the write strobe
`timescale 1ns/1ns
module sbd_rf_model (
  input  wire logic        clk,
  input  wire logic [11:0] addr,
  input  wire logic        we,
  input  wire logic [7:0]  wdata,
  output logic [7:0]       rdata
);
  // ==========
  // known contents, so no read ever returns an unknown
  logic [7:0] mem [4096];
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7 + 3);
  assign rdata = mem[addr];
  // plain always: the initial fill writes mem as well, which always_ff forbids
  always @(posedge clk)
  begin
    if (we) mem[addr] <= wdata;
  end
endmodule : sbd_rf_model

// File: sbd_datapath_sva.sv
// port checker for the subtract datapath
// assumes one clock and the synchronous reset
`timescale 1ns/1ns
module sbd_datapath_sva (
  input wire logic                clk,
  input wire logic                reset,
  input wire logic [15:0]         instr,
  input wire logic                instr_valid,
  input wire logic                ext_set_enable,
  input wire logic [3:0]          bank_select_register,
  input wire logic [11:0]         index_base,
  input wire logic [7:0]          file_rdata,
  input wire logic [11:0]         file_addr,
  input wire logic                file_we,
  input wire logic [7:0]          file_wdata,
  input wire logic [7:0]          wreg,
  input wire sbd_pkg::sbd_flags_s flags,
  input wire sbd_pkg::sbd_phase_e phase,
  input wire logic                busy
);
  // ==========
  // decoded takes; operands are sampled at the take edge
  wire take = phase == sbd_pkg::SBD_Q1 && instr_valid;
  wire lit  = take && instr[15:8] == 8'h08;
  wire fil  = take && instr[15:11] == 5'h0B;
  wire fa0  = fil && !instr[8];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_phase_step: assert property (1 |=> 2'(phase) == 2'($past(phase)) + 2'd1)
    else $error("phase skipped");
  chk_busy_span: assert property (lit || fil |=> busy [*3] ##1 !busy)
    else $error("busy span wrong");
  chk_lit_result: assert property (lit |-> ##3 !file_we
    && wreg == $past(instr[7:0], 3) - $past(wreg, 3)) else $error("literal result");
  chk_wreg_dest: assert property (fil && !instr[9] |-> ##3 !file_we)
    else $error("file written");
  chk_file_dest: assert property (fil && instr[9] |-> ##3 file_we && $stable(wreg))
    else $error("file not written");
  chk_file_diff: assert property (fil && instr[10] && instr[9] |-> ##3
    file_wdata == $past(file_rdata, 2) - $past(wreg, 3)) else $error("difference");
  chk_bank_sel: assert property (fil && instr[8] |=>
    file_addr == {$past(bank_select_register), $past(instr[7:0])}) else $error("bank");
  chk_access_hi: assert property (fa0 && instr[7:0] > 8'h5F |=>
    file_addr == {4'hF, $past(instr[7:0])}) else $error("access bank");
  chk_index_lo: assert property (fa0 && ext_set_enable && instr[7:0] < 8'h60 |=>
    file_addr == $past(index_base) + $past(instr[7:0])) else $error("indexed");
  chk_access_lo: assert property (fa0 && !ext_set_enable && instr[7:0] < 8'h60 |=>
    file_addr == {4'h0, $past(instr[7:0])}) else $error("access low");
  chk_borrow_diff: assert property (fil && !instr[10] && instr[9] |-> ##3
    file_wdata == $past(file_rdata, 2) - $past(wreg, 3) - 8'(!$past(flags.c, 3)))
    else $error("borrow difference");
  chk_zero_flag: assert property (lit |-> ##3 flags.z == (wreg == 8'h00))
    else $error("zero flag");
  chk_carry_flag: assert property (lit |-> ##3
    flags.c == ($past(instr[7:0], 3) >= $past(wreg, 3))) else $error("carry flag");
  cov_file_dest: cover property (fil && instr[9] && instr[8]);
  cov_lit: cover property (lit);
  cov_index: cover property (fa0 && ext_set_enable);
  cov_borrow: cover property (fil && !instr[10] && instr[9]);
endmodule : sbd_datapath_sva
bind sbd_datapath sbd_datapath_sva chk (.*);

// File: subtract_instruction_datapath_test.sv
// random and corner subtract words against the datapath
// assumes the register file model and the bound checker
`timescale 1ns/1ns
module subtract_instruction_datapath_test;
  logic clk = 0, reset = 1, iv = 0, ext = 0, we, busy;
  logic [15:0] instr = 0;
  logic [3:0] bank_sel = 4'h0;
  logic [11:0] base = 0, fa;
  logic [7:0] rd, wd, wreg, ew = 0;
  logic [31:0] seed = 12;
  sbd_pkg::sbd_flags_s flags, ef = '0;
  sbd_pkg::sbd_phase_e phase;
  int bad_count = 0, checks_done = 0;
  logic [7:0] cn [4] = '{8'h02, 8'h02, 8'h03, 8'h02};
  always #2 clk = ~clk;
  sbd_datapath dut (.clk(clk), .reset(reset), .instr(instr), .instr_valid(iv),
    .ext_set_enable(ext), .bank_select_register(bank_sel), .index_base(base), .file_rdata(rd),
    .file_addr(fa), .file_we(we), .file_wdata(wd), .wreg(wreg), .flags(flags),
    .phase(phase), .busy(busy));
  sbd_rf_model pm (.clk(clk), .addr(fa), .we(we), .wdata(wd), .rdata(rd));
  // ==========
  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [11:0] addr_of(logic [15:0] w);
    if (w[8]) return {bank_sel, w[7:0]};
    if (ext && w[7:0] < 8'h60) return base + 12'(w[7:0]);
    return {w[7:0] > 8'h5F ? 4'hF : 4'h0, w[7:0]};
  endfunction : addr_of
  // carry means no borrow, so the borrow input is the inverted carry
  function automatic sbd_pkg::sbd_result_s exp_sub(logic [7:0] m, s, logic ci);
    logic [8:0] d;
    d = {1'b0, m} - {1'b0, s} - 9'(!ci);
    return '{d[7:0], '{d[7], m[7] != s[7] && d[7] != m[7], d[7:0] == 8'h00,
      5'(m[3:0]) - 5'(s[3:0]) - 5'(!ci) < 5'h10, !d[8]}};
  endfunction : exp_sub
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // ==========
  // one word every four cycles, back to back, checked as the next one goes in
  initial
  begin
    logic [15:0] w;
    logic [11:0] a;
    logic [7:0] o;
    logic [1:0] kind;
    logic v;
    sbd_pkg::sbd_result_s e;
    repeat (16) @(negedge clk);
    reset = 0;
    for (int i = 0; i < 300; i++)
    begin
      w = 16'(rnd());
      kind = i < 4 ? 2'd2 : 2'(rnd());
      v = kind != 2'd3;
      case (kind)
        2'd0: w = {6'h17, w[9:0]};
        2'd1: w = {6'h16, w[9:0]};
        2'd2: w = {8'h08, i < 4 ? cn[i] : w[7:0]};
        default: w = {4'hE, w[11:0]};
      endcase
      {iv, ext, bank_sel, base} = 18'(rnd()) | 18'(v) << 17;
      instr = w;
      a = addr_of(w);
      o = pm.mem[a];
      e = w[14] ? exp_sub(o, ew, w[10] | ef.c) : exp_sub(w[7:0], ew, 1'b1);
      chk(phase === sbd_pkg::SBD_Q1, "phase");
      @(negedge clk);
      chk(busy === v, "busy");
      repeat (3) @(negedge clk);
      if (v) ef = e.flags;
      if (v && !(w[9] && w[14])) ew = e.value;
      chk(flags === ef, "flags");
      chk(wreg === ew, "wreg");
      chk(pm.mem[a] === (v && w[9] && w[14] ? e.value : o), "file");
    end
    $display("random and corner words done");
    test_done();
  end
endmodule : subtract_instruction_datapath_test
